// File: include/stall_adapt_defs.svh
// Offsets, field positions, reset values and the threshold scale shift of the stall/adapt block
`ifndef STALL_ADAPT_DEFS_SVH
`define STALL_ADAPT_DEFS_SVH
`define OFS_CONFIG 8'h00
`define OFS_THRESH 8'h04
`define OFS_ADAPT_LIMIT 8'h08
`define OFS_VMODE_LIMIT 8'h0c
`define OFS_ZERO_WAIT 8'h10
`define OFS_DRIVER_STATUS_REG 8'h14
`define OFS_PHASES 8'h18
`define OFS_IRQ_STATUS 8'h1c
`define OFS_IRQ_CLEAR 8'h20
`define OFS_IRQ_ENABLE 8'h24
`define OFS_RAMP_STATUS 8'h28
`define CFG_FILT_BIT 0
`define CFG_HALT_BIT 1
`define CFG_VMODE_BIT 2
`define CFG_UP_LSB 8
`define CFG_DN_LSB 10
`define CFG_MIN_BIT 12
`define CFG_RUN_LSB 16
`define THR_STALL_LSB 0
`define THR_LOWER_LSB 8
`define THR_UPPER_LSB 12
`define DRV_LOAD_LSB 0
`define DRV_CS_LSB 16
`define DRV_STALL_BIT 24
`define DRV_EVENT_BIT 25
`define IRQ_STALL_BIT 0
`define IRQ_STOP_BIT 1
`define RST_CONFIG 32'h001f0000
`define RST_THRESH 32'h00000000
`define RST_LIMIT 20'h00000
`define RST_ZERO_WAIT 16'h0000
`define RST_RUN_CURRENT 5'h1f
`define THRESH_SCALE_SHIFT 5
`endif

// File: include/stall_adapt_pkg.sv
// Types shared by the stall detection and current adaptation block
package stall_adapt_pkg;
    typedef logic [8:0] load_t;
    typedef logic [7:0] phase_t;
    typedef logic [4:0] scale_t;
    typedef enum logic {
        CHOP_CURRENT = 1'b0,
        CHOP_VOLTAGE = 1'b1
    } chop_t;
endpackage

// File: rtl/stall_adapt.sv
// Stall detection and load adaptive current scaling
//
// The address-and-strobe port and the placing of the registers were decided locally.
`include "stall_adapt_defs.svh"
module stall_adapt
    import stall_adapt_pkg::*;
(
    input wire logic MCLK, // 10 MHz clock
    input wire logic RST, // Synchronous reset, high
    input wire logic [7:0] ADDR, // Register byte address
    input wire logic [31:0] WDATA, // Register write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output logic [31:0] RDATA, // Read data, cycle after RD
    input wire logic ZERO_CROSS, // Coil zero transition pulse
    input wire logic [1:0] ZC_INDEX, // Transition kind 0..3
    input wire logic [7:0] ZC_SAMPLE, // Raw load sample
    input wire logic CM_VALID, // Current-mode reading pulse
    input wire logic [9:0] CM_LOAD, // Current-mode load reading
    input wire logic [19:0] STEP_INTERVAL, // Step interval
    output logic DIAG, // Stall pulse, one cycle
    output logic HALT_RAMP, // Ramp halted, velocity zero
    output logic [4:0] CURRENT_SCALE, // Present current scale
    output logic IRQ // Interrupt level
);
    logic [31:0] config_reg;
    logic [31:0] thresh_reg;
    logic [19:0] adapt_low_speed_limit;
    logic [19:0] voltage_mode_speed_limit;
    logic [15:0] zero_wait_time;
    phase_t phase_reading [4];
    load_t load_reading;
    logic new_reading;
    logic reading_ready;
    logic stall_flag;
    logic stall_stop_event;
    logic [15:0] wait_cnt;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    scale_t cs;
    logic [5:0] dn_cnt;

    // Field decode
    wire load_filter_enable = config_reg[`CFG_FILT_BIT];
    wire halt_on_stall = config_reg[`CFG_HALT_BIT];
    wire chop_t chop_mode = chop_t'(config_reg[`CFG_VMODE_BIT]);
    wire [1:0] current_step_up = config_reg[`CFG_UP_LSB +: 2];
    wire [1:0] current_step_down_rate = config_reg[`CFG_DN_LSB +: 2];
    wire min_current_select = config_reg[`CFG_MIN_BIT];
    wire [4:0] run_current = config_reg[`CFG_RUN_LSB +: 5];
    wire [7:0] stall_threshold = thresh_reg[`THR_STALL_LSB +: 8];
    wire [3:0] lower_load_threshold = thresh_reg[`THR_LOWER_LSB +: 4];
    wire [3:0] upper_load_band = thresh_reg[`THR_UPPER_LSB +: 4];

    // Bus decode
    wire wr_config = WR && ADDR == `OFS_CONFIG;
    wire wr_thresh = WR && ADDR == `OFS_THRESH;
    wire wr_alimit = WR && ADDR == `OFS_ADAPT_LIMIT;
    wire wr_vlimit = WR && ADDR == `OFS_VMODE_LIMIT;
    wire wr_wait = WR && ADDR == `OFS_ZERO_WAIT;
    wire wr_clear = WR && ADDR == `OFS_IRQ_CLEAR;
    wire wr_enable = WR && ADDR == `OFS_IRQ_ENABLE;
    wire wr_ramp = WR && ADDR == `OFS_RAMP_STATUS;
    wire event_clear = wr_ramp && WDATA[0];

    // Load reading sources
    wire [9:0] phase_sum = {2'b00, phase_reading[0]}
        + {2'b00, phase_reading[1]} + {2'b00, phase_reading[2]}
        + {2'b00, phase_reading[3]};
    wire load_t filtered = phase_sum[9:1];
    wire load_t unfiltered = {phase_reading[0], 1'b0};
    wire [1:0] store_idx = load_filter_enable ? ZC_INDEX : 2'd0;

    // Stall detection
    wire [8:0] stall_limit = {stall_threshold, 1'b0};
    wire stall_window = chop_mode == CHOP_VOLTAGE
        && adapt_low_speed_limit >= STEP_INTERVAL
        && STEP_INTERVAL > voltage_mode_speed_limit;
    // Compare only once the refreshed reading stands
    wire stall_hit = reading_ready && stall_window
        && load_reading < stall_limit;
    wire stall_stop = stall_hit && halt_on_stall;

    // Adaptation input and thresholds
    wire [9:0] adapt_load = chop_mode == CHOP_VOLTAGE ?
        {1'b0, load_reading} : CM_LOAD;
    wire adapt_valid = chop_mode == CHOP_VOLTAGE ? reading_ready :
        CM_VALID;
    wire adapt_on = lower_load_threshold != 4'h0;
    wire [9:0] lo_thr = {1'b0, lower_load_threshold, 5'h00};
    wire [5:0] band_sum = {2'b00, lower_load_threshold}
        + {2'b00, upper_load_band} + 6'h01;
    wire [10:0] hi_thr = {band_sum[5:0], 5'h00};
    wire below_lo = adapt_valid && adapt_on && adapt_load < lo_thr;
    wire above_hi = adapt_valid && adapt_on
        && {1'b0, adapt_load} >= hi_thr;
    wire [5:0] step_inc = 6'h01 << current_step_up;
    wire [5:0] inc_sum = {1'b0, cs} + step_inc;
    wire [4:0] cs_floor = min_current_select ? (run_current >> 2) :
        (run_current >> 1);
    wire [5:0] dn_need = current_step_down_rate == 2'd0 ? 6'd32 :
        current_step_down_rate == 2'd1 ? 6'd8 :
        current_step_down_rate == 2'd2 ? 6'd2 : 6'd1;
    wire [5:0] dn_next = dn_cnt + 6'h01;
    wire dn_fire = above_hi && dn_next >= dn_need;
    wire [4:0] cs_up = inc_sum > {1'b0, run_current} ? run_current :
        inc_sum[4:0];
    wire [4:0] cs_down = cs > cs_floor ? cs - 5'h01 : cs_floor;
    wire [4:0] cs_step = below_lo ? cs_up : dn_fire ? cs_down : cs;
    wire [4:0] next_cs = !adapt_on ? run_current :
        cs_step > run_current ? run_current :
        cs_step < cs_floor ? cs_floor : cs_step;

    // Read mux
    wire [31:0] driver_status_reg = {6'h00, stall_stop_event, stall_flag,
        3'h0, cs, 7'h00, load_reading};
    wire [31:0] phases = {phase_reading[3], phase_reading[2],
        phase_reading[1], phase_reading[0]};
    wire [31:0] next_rdata =
        ADDR == `OFS_CONFIG ? config_reg :
        ADDR == `OFS_THRESH ? thresh_reg :
        ADDR == `OFS_ADAPT_LIMIT ? {12'h000, adapt_low_speed_limit} :
        ADDR == `OFS_VMODE_LIMIT ? {12'h000, voltage_mode_speed_limit} :
        ADDR == `OFS_ZERO_WAIT ? {16'h0000, zero_wait_time} :
        ADDR == `OFS_DRIVER_STATUS_REG ? driver_status_reg :
        ADDR == `OFS_PHASES ? phases :
        ADDR == `OFS_IRQ_STATUS ? {30'h0, irq_status} :
        ADDR == `OFS_IRQ_ENABLE ? {30'h0, irq_enable} :
        ADDR == `OFS_RAMP_STATUS ? {31'h0, stall_stop_event} :
        32'h00000000;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            config_reg <= `RST_CONFIG;
            thresh_reg <= `RST_THRESH;
            adapt_low_speed_limit <= `RST_LIMIT;
            voltage_mode_speed_limit <= `RST_LIMIT;
            zero_wait_time <= `RST_ZERO_WAIT;
            irq_enable <= 2'h0;
            RDATA <= 32'h00000000;
        end else begin
            if (wr_config) config_reg <= WDATA;
            if (wr_thresh) thresh_reg <= {16'h0000, WDATA[15:0]};
            if (wr_alimit) adapt_low_speed_limit <= WDATA[19:0];
            if (wr_vlimit) voltage_mode_speed_limit <= WDATA[19:0];
            if (wr_wait) zero_wait_time <= WDATA[15:0];
            if (wr_enable) irq_enable <= WDATA[1:0];
            RDATA <= RD ? next_rdata : 32'h00000000;
        end
    end

    // Phase readings, one slot per transition kind with the filter on, only slot 0 with it off
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_phase
            always_ff @(posedge MCLK) begin
                if (RST) begin
                    phase_reading[gi] <= 8'h00;
                end else if (ZERO_CROSS && store_idx == 2'(gi)) begin
                    phase_reading[gi] <= ZC_SAMPLE;
                end
            end
        end
    endgenerate

    // Result follows the stored phase one cycle later
    always_ff @(posedge MCLK) begin
        if (RST) begin
            new_reading <= 1'b0;
            reading_ready <= 1'b0;
            load_reading <= 9'h000;
        end else begin
            new_reading <= ZERO_CROSS;
            reading_ready <= new_reading;
            if (new_reading) begin
                load_reading <= load_filter_enable ? filtered :
                    unfiltered;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            DIAG <= 1'b0;
            stall_flag <= 1'b0;
            stall_stop_event <= 1'b0;
            wait_cnt <= 16'h0000;
        end else begin
            DIAG <= stall_hit;
            if (stall_stop) begin
                stall_flag <= 1'b1;
                stall_stop_event <= 1'b1;
                wait_cnt <= 16'h0000;
            end else if (event_clear && stall_stop_event) begin
                stall_flag <= 1'b0;
                stall_stop_event <= 1'b0;
                wait_cnt <= zero_wait_time;
            end else if (wait_cnt != 16'h0000) begin
                wait_cnt <= wait_cnt - 16'h0001;
            end
        end
    end

    // Velocity held at zero while stopped and during zero wait
    assign HALT_RAMP = stall_stop_event || wait_cnt != 16'h0000;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            cs <= `RST_RUN_CURRENT;
            dn_cnt <= 6'h00;
        end else begin
            cs <= next_cs;
            if (below_lo || !adapt_on) begin
                dn_cnt <= 6'h00;
            end else if (above_hi) begin
                dn_cnt <= dn_fire ? 6'h00 : dn_next;
            end
        end
    end
    assign CURRENT_SCALE = cs;

    // Sticky interrupt status, set wins over clear
    always_ff @(posedge MCLK) begin
        if (RST) begin
            irq_status <= 2'h0;
        end else begin
            irq_status[`IRQ_STALL_BIT] <= stall_hit
                || (irq_status[`IRQ_STALL_BIT]
                && !(wr_clear && WDATA[`IRQ_STALL_BIT]));
            irq_status[`IRQ_STOP_BIT] <= stall_stop
                || (irq_status[`IRQ_STOP_BIT]
                && !(wr_clear && WDATA[`IRQ_STOP_BIT]));
        end
    end
    assign IRQ = |(irq_status & irq_enable);

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    diag_below_thr_a: assert property (
        reading_ready && stall_window && load_reading < stall_limit
        |=> DIAG)
        else $error("diag pulse missing on low reading");
    diag_window_a: assert property (
        DIAG |-> $past(chop_mode) == CHOP_VOLTAGE
        && $past(STEP_INTERVAL) > $past(voltage_mode_speed_limit))
        else $error("diag pulse outside enabled window");
    reading_once_a: assert property (
        !new_reading |=> $stable(load_reading))
        else $error("load reading changed without a step");
    unfilt_replace_a: assert property (
        ZERO_CROSS && !load_filter_enable ##1 !load_filter_enable
        |=> load_reading == {$past(ZC_SAMPLE, 2), 1'b0})
        else $error("unfiltered reading not replaced");
    phase_store_a: assert property (
        ZERO_CROSS && load_filter_enable
        |=> phase_reading[$past(ZC_INDEX)] == $past(ZC_SAMPLE))
        else $error("phase reading not stored at its index");
    filt_mean_a: assert property (
        new_reading && load_filter_enable |=> load_reading == $past(filtered))
        else $error("filtered reading not the mean");
    halt_stall_a: assert property (
        stall_stop |=> HALT_RAMP && stall_stop_event && stall_flag)
        else $error("stall stop not halting ramp");
    restart_wait_a: assert property (
        event_clear && stall_stop_event && !stall_stop
        && zero_wait_time == 16'h0003 |=> HALT_RAMP [*3] ##1 !HALT_RAMP)
        else $error("restart not after zero wait");
    adapt_off_a: assert property (
        !adapt_on |=> cs == $past(run_current))
        else $error("scale not at run current when disabled");
    scale_bound_a: assert property (
        adapt_on && $stable(config_reg) |=> cs <= run_current)
        else $error("current scale above run current");
    scale_up_a: assert property (
        below_lo && inc_sum <= {1'b0, run_current}
        && inc_sum[4:0] >= cs_floor |=> cs == $past(inc_sum[4:0]))
        else $error("current scale not raised by step");
    one_change_a: assert property (
        !adapt_valid && adapt_on && $stable(config_reg)
        && cs <= run_current && cs >= cs_floor |=> $stable(cs))
        else $error("current scale changed without a reading");

    stall_stop_c: cover property (stall_stop ##[1:20] event_clear);
    filt_update_c: cover property (new_reading && load_filter_enable);
    scale_down_c: cover property (dn_fire && cs > cs_floor);
    irq_c: cover property (IRQ);
endmodule

// File: verification/diag_watch.sv
// Motion controller model that counts stall pulses on the diagnostic pin
module diag_watch (
    input wire logic mclk, // Clock
    input wire logic rst, // Synchronous reset
    input wire logic diag, // Diagnostic pin
    output int pulses // Cycles seen with the pin active
);
    timeunit 1ns;
    timeprecision 1ns;

    // Each high cycle counts, so a stuck pin shows as extra pulses
    always @(posedge mclk) begin
        if (rst) begin
            pulses <= 0;
        end else if (diag === 1'b1) begin
            pulses <= pulses + 1;
        end
    end
endmodule

// File: verification/stall_adapt_test.sv
// Self-checking bench for the stall detection and current adaptation block
`include "stall_adapt_defs.svh"
module stall_adapt_test
    import stall_adapt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic MCLK, RST, WR, RD, ZERO_CROSS, CM_VALID, DIAG, HALT_RAMP, IRQ;
    logic [7:0] ADDR, ZC_SAMPLE;
    logic [31:0] WDATA, RDATA, rdv;
    logic [1:0] ZC_INDEX;
    logic [9:0] CM_LOAD;
    logic [19:0] STEP_INTERVAL;
    logic [4:0] CURRENT_SCALE;
    int error_cnt, check_count, exp_pulses, pulses, scale, dncnt, n;
    int slot[4];
    int vm, filt, halt, thr, lower, alim, vlim, si, up, dn;
    int sis[4] = '{100, 101, 10, 11};
    int need[4] = '{32, 8, 2, 1};

    stall_adapt DUT (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .ZERO_CROSS(ZERO_CROSS),
        .ZC_INDEX(ZC_INDEX), .ZC_SAMPLE(ZC_SAMPLE), .CM_VALID(CM_VALID),
        .CM_LOAD(CM_LOAD), .STEP_INTERVAL(STEP_INTERVAL), .DIAG(DIAG),
        .HALT_RAMP(HALT_RAMP), .CURRENT_SCALE(CURRENT_SCALE), .IRQ(IRQ));
    diag_watch watcher (.mclk(MCLK), .rst(RST), .diag(DIAG),
        .pulses(pulses));

    initial begin
        MCLK = 0;
        forever #50 MCLK = ~MCLK;
    end

    task automatic final_report();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    function automatic logic [31:0] cfg(int f, int h, int v);
        return {11'h0, 5'h1f, 3'h0, 1'b0, dn[1:0], up[1:0], 5'h0, v[0],
            h[0], f[0]};
    endfunction

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
        WDATA <= $urandom;
    endtask

    task automatic rd(logic [7:0] a);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        @(negedge MCLK);
        rdv = RDATA;
    endtask

    // One coil zero transition and the expected reading and stall pulse
    task automatic zc(int i, logic [7:0] s);
        int r;
        @(posedge MCLK);
        ZERO_CROSS <= 1'b1;
        ZC_INDEX <= i[1:0];
        ZC_SAMPLE <= s;
        @(posedge MCLK);
        ZERO_CROSS <= 1'b0;
        ZC_SAMPLE <= ~s;
        repeat (4) @(posedge MCLK);
        slot[filt ? i : 0] = s;
        r = filt ? (slot[0] + slot[1] + slot[2] + slot[3]) >> 1 : 2 * s;
        if (vm && alim >= si && si > vlim && r < 2 * thr) begin
            exp_pulses++;
            if (halt) n = 1;
        end
        @(negedge MCLK);
        chk("diag_pulses", exp_pulses, pulses);
        chk("halt_ramp", (halt && n == 1), HALT_RAMP);
        rd(`OFS_DRIVER_STATUS_REG);
        chk("load_reading", r, rdv[8:0]);
    endtask

    // One current-mode reading and the expected scale step
    task automatic cm(int v);
        @(posedge MCLK);
        CM_VALID <= 1'b1;
        CM_LOAD <= v[9:0];
        @(posedge MCLK);
        CM_VALID <= 1'b0;
        CM_LOAD <= $urandom;
        repeat (3) @(posedge MCLK);
        if (lower == 0) begin
            scale = 31;
            dncnt = 0;
        end else if (!vm && v < lower * 32) begin
            scale = (scale + (1 << up) > 31) ? 31 : scale + (1 << up);
            dncnt = 0;
        end else if (!vm && v >= (lower + 1) * 32
            && ++dncnt >= need[dn]) begin
            if (scale > 15) scale--;
            dncnt = 0;
        end
        @(negedge MCLK);
        chk("current_scale", scale, CURRENT_SCALE);
    endtask

    initial begin
        {WR, RD, ZERO_CROSS, CM_VALID, ADDR, ZC_INDEX, ZC_SAMPLE} = '0;
        {WDATA, CM_LOAD, STEP_INTERVAL} = '0;
        rdv = $urandom(32'h8d857b78);
        RST = 1'b1;
        repeat (4) @(posedge MCLK);
        RST <= 1'b0;
        rd(`OFS_CONFIG);
        chk("config_reset", 32'h001f0000, rdv);
        chk("scale_reset", 5'h1f, CURRENT_SCALE);
        rd(8'h40);
        chk("unmapped_read", 32'h0, rdv);
        thr = 60;
        alim = 100;
        vlim = 10;
        scale = 31;
        wr(`OFS_THRESH, 32'h3c);
        wr(`OFS_ADAPT_LIMIT, 32'h64);
        wr(`OFS_VMODE_LIMIT, 32'ha);
        for (vm = 0; vm < 2; vm++) begin
            for (int k = 0; k < 4; k++) begin
                si = sis[k];
                STEP_INTERVAL <= si[19:0];
                wr(`OFS_CONFIG, cfg(0, 0, vm));
                zc(0, 8'($urandom % 60));
                zc(0, 8'h3c);
            end
        end
        vm = 1;
        si = 50;
        STEP_INTERVAL <= 20'h32;
        filt = 1;
        wr(`OFS_CONFIG, cfg(1, 0, 1));
        for (int i = 0; i < 4; i++) zc(i, 8'($urandom));
        rd(`OFS_PHASES);
        chk("phases", {8'(slot[3]), 8'(slot[2]), 8'(slot[1]), 8'(slot[0])},
            rdv);
        filt = 0;
        halt = 1;
        wr(`OFS_IRQ_ENABLE, 32'h3);
        wr(`OFS_ZERO_WAIT, 32'h3);
        wr(`OFS_CONFIG, cfg(0, 1, 1));
        zc(0, 8'h05);
        chk("stall_flags", 2'b11, rdv[25:24]);
        chk("irq_on", 1'b1, IRQ);
        wr(`OFS_IRQ_ENABLE, 32'h0);
        @(negedge MCLK);
        chk("irq_masked", 1'b0, IRQ);
        wr(`OFS_RAMP_STATUS, 32'h1);
        n = 0;
        while (HALT_RAMP !== 1'b0 && n < 20) begin
            @(negedge MCLK);
            n++;
        end
        if (n >= 20) begin
            error_cnt++;
            final_report();
        end
        chk("restart_wait", 1'b1, n >= 3 && n <= 5);
        halt = 0;
        n = 0;
        rd(`OFS_DRIVER_STATUS_REG);
        chk("flags_cleared", 2'b00, rdv[25:24]);
        wr(`OFS_IRQ_CLEAR, 32'h3);
        wr(`OFS_IRQ_ENABLE, 32'h3);
        rd(`OFS_IRQ_STATUS);
        chk("irq_status", 32'h0, rdv);
        chk("irq_off", 1'b0, IRQ);
        vm = 0;
        up = 3;
        dn = 3;
        lower = 2;
        wr(`OFS_CONFIG, cfg(0, 0, 0));
        wr(`OFS_THRESH, 32'h023c);
        for (int i = 0; i < 10; i++) cm(96 + $urandom % 928);
        cm(63);
        dn = 2;
        wr(`OFS_CONFIG, cfg(0, 0, 0));
        for (int i = 0; i < 4; i++) cm(96 + $urandom % 928);
        cm(95);
        lower = 0;
        wr(`OFS_THRESH, 32'h003c);
        cm(10);
        lower = 2;
        vm = 1;
        wr(`OFS_THRESH, 32'h023c);
        wr(`OFS_CONFIG, cfg(0, 0, 1));
        cm(300);
        final_report();
    end
endmodule
